// ===== logic/ipnf_top.sv
// ipnf_top: noise filter for the irq-six pin and the nine timer input pins.
// assumes pins and register port are synchronous-ready at clk_i, 100 MHz.
//
// Added by the designer: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module ipnf_top (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [ipnf_pkg::ADDR_W-1:0] addr_i,
  input wire logic [ipnf_pkg::DATA_W-1:0] wr_data_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  output logic [ipnf_pkg::DATA_W-1:0] rd_data_o,
  input wire logic [ipnf_pkg::NUM_CH-1:0] alt_fn_en_i,
  input wire logic ext_irq_six_pin_i,
  input wire logic timer_q_capture_in0_i,
  input wire logic timer_q_capture_in1_i,
  input wire logic timer_q_capture_in2_i,
  input wire logic timer_q_capture_in3_i,
  input wire logic timer_q_event_in_i,
  input wire logic timer_p0_capture_in0_i,
  input wire logic timer_p0_capture_in1_i,
  input wire logic timer_p2_capture_in0_i,
  input wire logic timer_p2_capture_in1_i,
  output logic ext_irq_six_filt_o,
  output logic timer_q_capture_in0_filt_o,
  output logic timer_q_capture_in1_filt_o,
  output logic timer_q_capture_in2_filt_o,
  output logic timer_q_capture_in3_filt_o,
  output logic timer_q_event_in_filt_o,
  output logic timer_p0_capture_in0_filt_o,
  output logic timer_p0_capture_in1_filt_o,
  output logic timer_p2_capture_in0_filt_o,
  output logic timer_p2_capture_in1_filt_o,
  output logic ext_irq_six_wake_o
);
  import ipnf_pkg::*;

  logic [1:0] sel_q;
  logic [1:0] sel_d;
  logic [DIV_W-1:0] div_q;
  logic [DIV_W-1:0] div_d;
  logic restart_q;
  logic [DATA_W-1:0] rd_data_q;
  logic [DATA_W-1:0] rd_data_d;
  logic wake_q;
  logic [DIV_W-1:0] div_mask;
  logic [NUM_CH-1:0] raw;
  logic [NUM_CH-1:0] filt;
  ipnf_samp_if samp ();

  // register decode
  wire addr_hit = addr_i == FILT_SEL_ADDR;
  wire wr_hit = wr_en_i && addr_hit;
  wire [1:0] sel_wr = wr_data_i[SEL_HI_BIT:SEL_LO_BIT];
  wire sel_change = wr_hit && (sel_wr != sel_q);
  wire [DATA_W-1:0] sel_read = {SEL_PAD, sel_q};

  assign sel_d = wr_hit ? sel_wr : sel_q;
  assign rd_data_d = (rd_en_i && addr_hit) ? sel_read : RD_ZERO;

  // register holds only the two select bits; upper bits cannot be stored
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sel_q <= SEL_RESET;
      rd_data_q <= RD_ZERO;
      restart_q <= 1'b0;
    end else begin
      sel_q <= sel_d;
      rd_data_q <= rd_data_d;
      restart_q <= sel_change;
    end
  end

  assign rd_data_o = rd_data_q;

  // divider select for the irq-six sampling strobe
  always_comb begin
    case (sel_q)
      SEL_DIV16: div_mask = MASK_DIV16;
      SEL_DIV8: div_mask = MASK_DIV8;
      SEL_DIV4: div_mask = MASK_DIV4;
      SEL_DIV2: div_mask = MASK_DIV2;
      default: div_mask = MASK_DIV16;
    endcase
  end

  // free-running prescaler, realigned on a divider change
  assign div_d = restart_q ? DIV_RESET : div_q + 4'h1;
  wire irq_tick = (div_q & div_mask) == div_mask;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div_q <= DIV_RESET;
    end else begin
      div_q <= div_d;
    end
  end

  // irq-six uses the divided strobe, timer pins sample every clock
  assign samp.tick = {ALL_TICK[NUM_CH-1:1], irq_tick};
  assign samp.restart = {{(NUM_CH-1){1'b0}}, restart_q};

  assign raw = {timer_p2_capture_in1_i, timer_p2_capture_in0_i,
                timer_p0_capture_in1_i, timer_p0_capture_in0_i,
                timer_q_event_in_i, timer_q_capture_in3_i,
                timer_q_capture_in2_i, timer_q_capture_in1_i,
                timer_q_capture_in0_i, ext_irq_six_pin_i};

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      ipnf_filter #(
        .CH(g)
      ) u_filter (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .samp(samp),
        .raw_i(raw[g]),
        .alt_en_i(alt_fn_en_i[g]),
        .filt_o(filt[g])
      );
    end
  endgenerate

  assign ext_irq_six_filt_o = filt[CH_IRQ6];
  assign timer_q_capture_in0_filt_o = filt[1];
  assign timer_q_capture_in1_filt_o = filt[2];
  assign timer_q_capture_in2_filt_o = filt[3];
  assign timer_q_capture_in3_filt_o = filt[4];
  assign timer_q_event_in_filt_o = filt[5];
  assign timer_p0_capture_in0_filt_o = filt[6];
  assign timer_p0_capture_in1_filt_o = filt[7];
  assign timer_p2_capture_in0_filt_o = filt[8];
  assign timer_p2_capture_in1_filt_o = filt[9];

  // the sampled path cannot run in standby, so it never offers a wake
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= 1'b0;
    end
  end

  assign ext_irq_six_wake_o = wake_q;

  a_read_one_cycle: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (rd_en_i && addr_hit) |=> (rd_data_o == {SEL_PAD, $past(sel_q)}))
    else $error("read data is not the select register");

  a_read_idle_zero: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    !(rd_en_i && addr_hit) |=> (rd_data_o == RD_ZERO))
    else $error("read data not zero outside a read");

  a_sel_write_takes: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    wr_hit |=> (sel_q == $past(wr_data_i[SEL_HI_BIT:SEL_LO_BIT])))
    else $error("select write not stored");

  a_restart_on_change: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    sel_change |=> restart_q ##1 (div_q == DIV_RESET))
    else $error("divider change did not restart sampling");

  a_div2_spacing: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (sel_q == SEL_DIV2 && irq_tick && !restart_q && !sel_change) |=>
      !irq_tick ##1 (irq_tick || sel_q != SEL_DIV2 || restart_q))
    else $error("divide by two strobe spacing wrong");

  a_div16_spacing: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (sel_q == SEL_DIV16 && irq_tick && !restart_q && !sel_change) |=>
      !irq_tick [*8])
    else $error("divide by sixteen strobe too early");

  a_timer_full_rate: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    samp.tick[NUM_CH-1:1] == ALL_TICK[NUM_CH-1:1])
    else $error("timer filter strobe not every clock");

  a_no_irq_wake: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    !ext_irq_six_wake_o)
    else $error("irq six offered as wake source");

endmodule : ipnf_top
`default_nettype wire

// ===== logic/ipnf_pkg.sv
// ipnf_pkg: constants shared by the pin noise filter top and its channels.
// assumes a single peripheral clock domain and a byte-wide register port.
`default_nettype none
package ipnf_pkg;
  localparam int NUM_CH = 10;
  localparam int CH_IRQ6 = 0;
  localparam int SEL_LO_BIT = 0;
  localparam int SEL_HI_BIT = 1;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 32;
  localparam int CNT_W = 3;
  localparam int DIV_W = 4;
  localparam logic [ADDR_W-1:0] FILT_SEL_ADDR = 32'hfffff310;
  localparam logic [1:0] SEL_RESET = 2'h0;
  localparam logic [1:0] SEL_DIV16 = 2'h0;
  localparam logic [1:0] SEL_DIV8 = 2'h1;
  localparam logic [1:0] SEL_DIV4 = 2'h2;
  localparam logic [1:0] SEL_DIV2 = 2'h3;
  localparam logic [DIV_W-1:0] MASK_DIV16 = 4'hf;
  localparam logic [DIV_W-1:0] MASK_DIV8 = 4'h7;
  localparam logic [DIV_W-1:0] MASK_DIV4 = 4'h3;
  localparam logic [DIV_W-1:0] MASK_DIV2 = 4'h1;
  localparam logic [DIV_W-1:0] DIV_RESET = 4'h0;
  // a differing sample with the count at this value is the fifth in a row
  localparam logic [CNT_W-1:0] ACCEPT_CNT = 3'h4;
  localparam logic [CNT_W-1:0] CNT_RESET = 3'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 3'h1;
  localparam logic [DATA_W-1:0] RD_ZERO = 8'h00;
  localparam logic [DATA_W-3:0] SEL_PAD = 6'h00;
  localparam logic [NUM_CH-1:0] ALL_TICK = 10'h3ff;
endpackage : ipnf_pkg
`default_nettype wire

// ===== logic/ipnf_samp_if.sv
// ipnf_samp_if: per-channel sample strobes and count restarts.
// assumes the driver and all channels share the peripheral clock.
`timescale 1ns/100ps
`default_nettype none
interface ipnf_samp_if;
  import ipnf_pkg::*;
  logic [NUM_CH-1:0] tick;
  logic [NUM_CH-1:0] restart;
  modport src (output tick, output restart);
  modport snk (input tick, input restart);
endinterface : ipnf_samp_if
`default_nettype wire

// ===== logic/ipnf_filter.sv
// ipnf_filter: one input channel, synchroniser plus five-sample acceptor.
// assumes tick and restart come from the top in the same clock domain.
`timescale 1ns/100ps
`default_nettype none
module ipnf_filter #(
  parameter int CH = 0
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  ipnf_samp_if.snk samp,
  input wire logic raw_i,
  input wire logic alt_en_i,
  output logic filt_o
);
  import ipnf_pkg::*;

  logic sync1_q;
  logic sync2_q;
  logic stable_q;
  logic stable_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic filt_q;
  logic filt_d;
  wire tick = samp.tick[CH];
  wire restart = samp.restart[CH];
  wire differs = sync2_q != stable_q;
  wire accept = tick && differs && (cnt_q == ACCEPT_CNT);

  // two flops ahead of the counter; only sync2_q is looked at
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= raw_i;
      sync2_q <= sync1_q;
    end
  end

  // counting happens only on clock edges, so a stopped clock sees nothing
  always_comb begin
    stable_d = stable_q;
    cnt_d = cnt_q;
    if (!alt_en_i) begin
      // port mode: track the pin so switching over makes no false edge
      stable_d = sync2_q;
      cnt_d = CNT_RESET;
    end else if (restart) begin
      cnt_d = CNT_RESET;
    end else if (tick) begin
      if (!differs) begin
        cnt_d = CNT_RESET;
      end else if (accept) begin
        stable_d = sync2_q;
        cnt_d = CNT_RESET;
      end else begin
        cnt_d = cnt_q + CNT_ONE;
      end
    end
  end

  assign filt_d = alt_en_i ? stable_d : sync2_q;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      stable_q <= 1'b0;
      cnt_q <= CNT_RESET;
      filt_q <= 1'b0;
    end else begin
      stable_q <= stable_d;
      cnt_q <= cnt_d;
      filt_q <= filt_d;
    end
  end

  assign filt_o = filt_q;

  a_accept_after_five: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    ($past(alt_en_i) && alt_en_i && $changed(stable_q)) |->
      ($past(cnt_q) == ACCEPT_CNT && $past(tick) && !$past(restart)))
    else $error("filtered level changed without five samples");

  a_glitch_resets_count: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (alt_en_i && tick && !restart && !differs) |=> (cnt_q == CNT_RESET))
    else $error("reverted level did not restart the count");

  a_restart_clears: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (alt_en_i && restart) |=> (cnt_q == CNT_RESET && $stable(stable_q)))
    else $error("divider change did not restart the count");

  a_port_passthru: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    !alt_en_i |=> (filt_q == $past(sync2_q)))
    else $error("port mode output is not the raw level");

  a_out_follows_stable: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    alt_en_i |=> (filt_q == stable_q))
    else $error("filtered output differs from accepted level");

endmodule : ipnf_filter
`default_nettype wire

// ===== tb/ipnf_src_model.sv
// ipnf_src_model: off-chip source driving the ten filtered pins.
// assumes the bench calls its tasks from the clk_i domain.
`timescale 1ns/100ps
`default_nettype none
module ipnf_src_model (
  input wire logic clk_i,
  output logic [ipnf_pkg::NUM_CH-1:0] pin_o
);
  import ipnf_pkg::*;
  initial pin_o = '0;
  // holds v for n clocks; callers glitch with n of three samples at most
  task automatic drive(input logic [NUM_CH-1:0] v, input int n);
    @(posedge clk_i);
    pin_o <= v;
    repeat (n - 1) @(posedge clk_i);
  endtask : drive
  // only for use while the clock is stopped
  task automatic set_now(input logic [NUM_CH-1:0] v);
    pin_o = v;
  endtask : set_now
endmodule : ipnf_src_model
`default_nettype wire

// ===== tb/tb_top.sv
// tb_top: random and corner-case bench for the pin noise filter.
// assumes ipnf_pkg constants and the source model in ipnf_src_model.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import ipnf_pkg::*;
  logic clk_i, arst_n_i, wr_en, rd_en, wake, clk_run;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rd_data, d, v;
  logic [NUM_CH-1:0] alt, pins, filt, cur, nv, pm, seen;
  int num_errors, tests_run, n;
  ipnf_src_model u_ipnf_src_model (.clk_i(clk_i), .pin_o(pins));
  ipnf_top u_ipnf_top (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr), .wr_data_i(wdata),
    .wr_en_i(wr_en), .rd_en_i(rd_en), .rd_data_o(rd_data),
    .alt_fn_en_i(alt), .ext_irq_six_pin_i(pins[0]),
    .timer_q_capture_in0_i(pins[1]), .timer_q_capture_in1_i(pins[2]),
    .timer_q_capture_in2_i(pins[3]), .timer_q_capture_in3_i(pins[4]),
    .timer_q_event_in_i(pins[5]), .timer_p0_capture_in0_i(pins[6]),
    .timer_p0_capture_in1_i(pins[7]), .timer_p2_capture_in0_i(pins[8]),
    .timer_p2_capture_in1_i(pins[9]), .ext_irq_six_filt_o(filt[0]),
    .timer_q_capture_in0_filt_o(filt[1]), .timer_q_capture_in1_filt_o(filt[2]),
    .timer_q_capture_in2_filt_o(filt[3]), .timer_q_capture_in3_filt_o(filt[4]),
    .timer_q_event_in_filt_o(filt[5]), .timer_p0_capture_in0_filt_o(filt[6]),
    .timer_p0_capture_in1_filt_o(filt[7]),
    .timer_p2_capture_in0_filt_o(filt[8]),
    .timer_p2_capture_in1_filt_o(filt[9]), .ext_irq_six_wake_o(wake)
  );
  // gating the clock lets the stopped-clock case be exercised
  initial begin
    clk_i = 1'b0;
    forever #5 if (clk_run) clk_i = ~clk_i;
  end
  function automatic int div_of(input logic [1:0] s);
    return 16 >> s;
  endfunction : div_of
  function automatic logic [DATA_W-1:0] exp_sel(input logic [DATA_W-1:0] w);
    return {SEL_PAD, w[1:0]};
  endfunction : exp_sel
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] w);
    @(posedge clk_i);
    addr <= a;
    wdata <= w;
    wr_en <= 1'b1;
    @(posedge clk_i);
    wr_en <= 1'b0;
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] r);
    @(posedge clk_i);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_i);
    rd_en <= 1'b0;
    #1 r = rd_data;
  endtask : rd
  task automatic chk8(input string what, input logic [7:0] e,
                      input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask : chk8
  task automatic chk1(input string what, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %b seen %b", what, e, g);
    end
  endtask : chk1
  task automatic chkv(input string what, input logic [9:0] e,
                      input logic [9:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask : chkv
  task automatic conclude;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude
  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    conclude();
  end
  initial begin
    clk_run = 1'b1;
    arst_n_i = 1'b0;
    {wr_en, rd_en, addr, wdata} = '0;
    alt = '1;
    num_errors = 0;
    tests_run = 0;
    cur = '0;
    v = $urandom(66);
    repeat (8) @(posedge clk_i);
    arst_n_i <= 1'b1;
    rd(FILT_SEL_ADDR, d);
    chk8("select reset", 8'h00, d);
    chk1("wake", 1'b0, wake);
    repeat (6) begin
      v = $urandom;
      wr(FILT_SEL_ADDR, v);
      wr(FILT_SEL_ADDR + 1, ~v);
      rd(FILT_SEL_ADDR + 1, d);
      chk8("unmapped", 8'h00, d);
      rd(FILT_SEL_ADDR, d);
      chk8("select rw", exp_sel(v), d);
    end
    for (int s = 0; s < 4; s++) begin
      n = div_of(s[1:0]);
      wr(FILT_SEL_ADDR, s[7:0]);
      u_ipnf_src_model.drive(10'h001, 3 * n);
      u_ipnf_src_model.drive(10'h000, 8 * n);
      chk1("irq glitch", 1'b0, filt[0]);
      u_ipnf_src_model.drive(10'h001, 3 * n);
      #1 chk1("irq early", 1'b0, filt[0]);
      repeat (2 * n + 8) @(posedge clk_i);
      #1 chk1("irq accept", 1'b1, filt[0]);
      u_ipnf_src_model.drive(10'h000, 6 * n + 8);
      #1 chk1("irq fall", 1'b0, filt[0]);
    end
    wr(FILT_SEL_ADDR, 8'h00);
    u_ipnf_src_model.drive(10'h001, 58);
    wr(FILT_SEL_ADDR, 8'h03);
    // old-rate samples would accept by the sixth clock without a restart
    repeat (8) @(posedge clk_i);
    #1 chk1("restart", 1'b0, filt[0]);
    repeat (6) @(posedge clk_i);
    #1 chk1("restart accept", 1'b1, filt[0]);
    u_ipnf_src_model.drive(10'h000, 20);
    repeat (8) begin
      nv = cur ^ (10'($urandom) & 10'h3fe);
      u_ipnf_src_model.drive(nv, 3);
      u_ipnf_src_model.drive(cur, 10);
      #1 chkv("timer glitch", cur, filt);
      u_ipnf_src_model.drive(nv, 10);
      #1 chkv("timer accept", nv, filt);
      cur = nv;
    end
    pm = 10'($urandom);
    @(posedge clk_i);
    alt <= ~pm;
    u_ipnf_src_model.drive(cur ^ pm, 1);
    u_ipnf_src_model.drive(cur, 1);
    seen = '0;
    repeat (6) begin
      #1 seen = seen | (filt ^ cur);
      @(posedge clk_i);
    end
    chkv("port mode", pm, seen);
    alt <= '1;
    @(negedge clk_i);
    clk_run = 1'b0;
    #1000 u_ipnf_src_model.set_now(~cur);
    #2000 u_ipnf_src_model.set_now(cur);
    #1000 clk_run = 1'b1;
    repeat (12) @(posedge clk_i);
    #1 chkv("clock stopped", cur, filt);
    conclude();
  end
endmodule : tb_top
`default_nettype wire
